// file: io_irq_events.sv
/*
 * io_irq_events: event logic of the on-board i/o that raises process and
 * diagnostic interrupts and reports the cause word and module base address.
 * assumes field pins are asynchronous, counter values, compare values and
 * limit pulses come from counter logic on clk_in, and an apb master on clk_in.
 */
//
// Contract
// - enabled input edge raises process interrupt
// - counter reaching compare value raises interrupt
// - counter overflow or underflow raises interrupt
// - gate change with software gate, not counter3
// - lost, supply or short raise diagnostic
// - channel interrupts only under diag plus process
// - start routine, supply module base address
// - cause word layout follows operating mode
// - cause byte 8 mirrors input byte 0
// - cause byte 9 mirrors input byte 1
`timescale 1ns/1ns
`default_nettype none

module io_irq_events (
	input  wire logic              clk_in,
	input  wire logic              srst_in,
	input  wire logic              psel_in,
	input  wire logic              penable_in,
	input  wire logic              pwrite_in,
	input  wire logic [7:0]        paddr_in,
	input  wire logic [31:0]       pwdata_in,
	output var  logic [31:0]       prdata_out,
	output logic                   pready_out,
	output logic                   pslverr_out,
	input  wire logic [15:0]       di_in,
	input  wire logic [3:0][31:0]  cnt_value_in,
	input  wire logic [3:0][31:0]  cnt_cmp_in,
	input  wire logic [3:0]        cnt_ovf_in,
	input  wire logic [3:0]        cnt_unf_in,
	input  wire logic [3:0]        hardware_count_gate_in,
	input  wire logic [3:0]        software_count_gate_in,
	input  wire logic              do_supply_fail_in,
	input  wire logic              di_supply_fail_in,
	input  wire logic              do_short_in,
	output var  logic              process_irq_out,
	output var  logic [31:0]       cause_out,
	output var  logic [15:0]       base_addr_out,
	output logic                   diag_irq_out
);

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b01,
		ST_ACTIVE = 2'b10
	} pstate_t;

	pstate_t     state_q, state_d;
	logic [31:0] ctrl_q, ctrl_d;
	logic [15:0] di_en_q, di_en_d;
	logic [31:0] edge_q, edge_d;
	logic [15:0] cnt_en_q, cnt_en_d;
	logic [3:0]  diag_en_q, diag_en_d;
	logic [15:0] base_q, base_d;
	logic [31:0] pend_q, pend_d;
	logic [31:0] cause_q, cause_d;
	logic [15:0] pbase_q, pbase_d;
	logic [3:0]  diag_q, diag_d;
	logic [31:0] rdata_q, rdata_d;
	logic [15:0] di_s1_q, di_s2_q, di_prev_q;
	logic [3:0]  gate_s1_q, gate_s2_q, gate_prev_q;
	logic [2:0]  pin_s1_q, pin_s2_q, pin_prev_q;
	logic [3:0]  cmp_eq_q, cmp_eq_d;

	logic        sel_dp;
	logic        cnt_mode;
	logic        wr_acc;
	logic        rd_setup;
	logic        mapped;
	logic        lost;
	logic [15:0] di_hit;
	logic [3:0]  cmp_hit;
	logic [31:0] ev;
	logic [3:0]  diag_ev;

	assign sel_dp = (ctrl_q[io_irq_pkg::SEL_LSB +: 2] == io_irq_pkg::SEL_DIAG_PROC);
	assign cnt_mode = ctrl_q[io_irq_pkg::MODE_BIT];
	assign wr_acc = psel_in & penable_in & pwrite_in & mapped;
	assign rd_setup = psel_in & ~penable_in & ~pwrite_in;
	assign mapped = (paddr_in[1:0] == 2'h0) && (paddr_in <= io_irq_pkg::STATUS_OFS);

	// zero wait states; unmapped or misaligned addresses answer with an error
	assign pready_out = 1'b1;
	assign pslverr_out = psel_in & penable_in & ~mapped;
	assign prdata_out = rdata_q;
	assign process_irq_out = (state_q == ST_ACTIVE);
	assign cause_out = cause_q;
	assign base_addr_out = pbase_q;
	assign diag_irq_out = |diag_q;

	always_comb begin
		ctrl_d = ctrl_q;
		di_en_d = di_en_q;
		edge_d = edge_q;
		cnt_en_d = cnt_en_q;
		diag_en_d = diag_en_q;
		base_d = base_q;
		state_d = state_q;
		cause_d = cause_q;
		pbase_d = pbase_q;
		rdata_d = rdata_q;
		ev = '0;
		di_hit = di_en_q & ((di_s2_q & ~di_prev_q & edge_q[15:0])
			| (~di_s2_q & di_prev_q & edge_q[31:io_irq_pkg::FALL_LSB]));
		for (int c = 0; c < 4; c++) begin
			cmp_eq_d[c] = (cnt_value_in[c] == cnt_cmp_in[c]);
			cmp_hit[c] = cmp_eq_d[c] & ~cmp_eq_q[c];
		end
		if (cnt_mode) begin
			for (int c = 0; c < 4; c++) begin
				ev[8*c + io_irq_pkg::CB_CMP] = cmp_hit[c] & cnt_en_q[4*c + io_irq_pkg::CEN_CMP];
				ev[8*c + io_irq_pkg::CB_OVUN] =
					(cnt_ovf_in[c] & cnt_en_q[4*c + io_irq_pkg::CEN_OVF])
					| (cnt_unf_in[c] & cnt_en_q[4*c + io_irq_pkg::CEN_UNF]);
				if (c < 3) begin
					ev[8*c + io_irq_pkg::CB_GOPEN] = gate_s2_q[c] & ~gate_prev_q[c]
						& software_count_gate_in[c] & cnt_en_q[4*c + io_irq_pkg::CEN_GATE];
					ev[8*c + io_irq_pkg::CB_GCLOSE] = ~gate_s2_q[c] & gate_prev_q[c]
						& software_count_gate_in[c] & cnt_en_q[4*c + io_irq_pkg::CEN_GATE];
				end
			end
		end else begin
			ev[7:0] = di_hit[7:0];
			ev[15:8] = di_hit[15:8];
			// bytes 10 and 11 stay zero
			ev[31:16] = 16'h0000;
		end
		// channel events need diag plus process
		if (!sel_dp) begin
			ev = '0;
		end
		// an event already waiting or being served is flagged as lost, though it is still queued in pend
		lost = |(ev & (pend_q | (process_irq_out ? cause_q : 32'h0000_0000)));
		pend_d = pend_q | ev;
		case (state_q)
			ST_IDLE: begin
				if (pend_q != 32'h0000_0000) begin
					cause_d = pend_q;
					pbase_d = base_q;
					pend_d = ev;
					state_d = ST_ACTIVE;
				end
			end
			ST_ACTIVE: begin
				if (wr_acc && paddr_in == io_irq_pkg::CAUSE_OFS) begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
		diag_ev[io_irq_pkg::DG_LOST] = lost;
		diag_ev[io_irq_pkg::DG_DOPWR] = pin_s2_q[0] & ~pin_prev_q[0];
		diag_ev[io_irq_pkg::DG_DIPWR] = pin_s2_q[1] & ~pin_prev_q[1];
		diag_ev[io_irq_pkg::DG_SHORT] = pin_s2_q[2] & ~pin_prev_q[2];
		if (ctrl_q[io_irq_pkg::SEL_LSB +: 2] == io_irq_pkg::SEL_NONE) begin
			diag_ev = 4'h0;
		end
		diag_d = diag_q;
		if (wr_acc && paddr_in == io_irq_pkg::STATUS_OFS) begin
			diag_d = diag_q & ~pwdata_in[io_irq_pkg::STAT_DIAG_LSB +: 4];
		end
		// a new fault wins over a clear in the same cycle
		diag_d = diag_d | (diag_ev & diag_en_q);
		if (wr_acc) begin
			case (paddr_in)
				io_irq_pkg::CTRL_OFS:    ctrl_d = {29'h0, pwdata_in[2:0]};
				io_irq_pkg::DI_EN_OFS:   di_en_d = pwdata_in[15:0];
				io_irq_pkg::DI_EDGE_OFS: edge_d = pwdata_in;
				io_irq_pkg::CNT_EN_OFS:  cnt_en_d = pwdata_in[15:0];
				io_irq_pkg::DIAG_EN_OFS: diag_en_d = pwdata_in[3:0];
				io_irq_pkg::BASE_OFS:    base_d = pwdata_in[15:0];
				default: ;
			endcase
		end
		if (rd_setup) begin
			case (paddr_in)
				io_irq_pkg::CTRL_OFS:    rdata_d = ctrl_q;
				io_irq_pkg::DI_EN_OFS:   rdata_d = {16'h0, di_en_q};
				io_irq_pkg::DI_EDGE_OFS: rdata_d = edge_q;
				io_irq_pkg::CNT_EN_OFS:  rdata_d = {16'h0, cnt_en_q};
				io_irq_pkg::DIAG_EN_OFS: rdata_d = {28'h0, diag_en_q};
				io_irq_pkg::BASE_OFS:    rdata_d = {16'h0, base_q};
				io_irq_pkg::CAUSE_OFS:   rdata_d = cause_q;
				io_irq_pkg::STATUS_OFS:  rdata_d = {24'h0, diag_q, 3'h0, process_irq_out};
				default:                 rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		// pin synchronisers; the first stage feeds only the second
		di_s1_q <= di_in;
		di_s2_q <= di_s1_q;
		gate_s1_q <= hardware_count_gate_in;
		gate_s2_q <= gate_s1_q;
		pin_s1_q <= {do_short_in, di_supply_fail_in, do_supply_fail_in};
		pin_s2_q <= pin_s1_q;
		if (srst_in) begin
			state_q <= ST_IDLE;
			ctrl_q <= io_irq_pkg::REG_RST;
			di_en_q <= io_irq_pkg::REG_RST[15:0];
			edge_q <= io_irq_pkg::REG_RST;
			cnt_en_q <= io_irq_pkg::REG_RST[15:0];
			diag_en_q <= io_irq_pkg::REG_RST[3:0];
			base_q <= io_irq_pkg::REG_RST[15:0];
			pend_q <= io_irq_pkg::REG_RST;
			cause_q <= io_irq_pkg::REG_RST;
			pbase_q <= io_irq_pkg::REG_RST[15:0];
			diag_q <= io_irq_pkg::REG_RST[3:0];
			rdata_q <= io_irq_pkg::REG_RST;
			cmp_eq_q <= 4'hf;
			di_prev_q <= di_s2_q;
			gate_prev_q <= gate_s2_q;
			pin_prev_q <= pin_s2_q;
		end else begin
			state_q <= state_d;
			ctrl_q <= ctrl_d;
			di_en_q <= di_en_d;
			edge_q <= edge_d;
			cnt_en_q <= cnt_en_d;
			diag_en_q <= diag_en_d;
			base_q <= base_d;
			pend_q <= pend_d;
			cause_q <= cause_d;
			pbase_q <= pbase_d;
			diag_q <= diag_d;
			rdata_q <= rdata_d;
			cmp_eq_q <= cmp_eq_d;
			di_prev_q <= di_s2_q;
			gate_prev_q <= gate_s2_q;
			pin_prev_q <= pin_s2_q;
		end
	end

	sequence dispatch_s;
		state_q == ST_IDLE && pend_q != 32'h0000_0000;
	endsequence

	sequence lost_s;
		lost && diag_en_q[0] && ctrl_q[1:0] != 2'h0;
	endsequence

	di_edge_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(sel_dp && !cnt_mode && di_hit != 16'h0)
		|=> ((pend_q[15:0] & $past(di_hit)) == $past(di_hit)))
		else $error("input edge not queued");

	cmp_reach_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(sel_dp && cnt_mode && cmp_hit[0] && cnt_en_q[0]) |=> pend_q[3])
		else $error("compare hit not queued");

	limit_pass_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(sel_dp && cnt_mode && cnt_unf_in[1] && cnt_en_q[6]) |=> pend_q[10])
		else $error("underflow not queued");

	gate3_none_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(pend_q[25:24] == 2'h0) && (cause_q[25:24] == 2'h0))
		else $error("counter 3 gate event raised");

	lost_diag_a: assert property (@(posedge clk_in) disable iff (srst_in)
		lost_s |=> diag_q[0] ##0 diag_irq_out)
		else $error("lost interrupt not flagged");

	sel_block_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(!sel_dp && pend_q == 32'h0000_0000) |=> pend_q == 32'h0000_0000)
		else $error("event queued without selection");

	start_base_a: assert property (@(posedge clk_in) disable iff (srst_in)
		dispatch_s |=> process_irq_out && cause_out == $past(pend_q)
			&& base_addr_out == $past(base_q))
		else $error("routine start wrong");

	upper_zero_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(!cnt_mode && !process_irq_out) ##1 (!cnt_mode && process_irq_out)
		|-> cause_out[31:16] == 16'h0000)
		else $error("reserved cause bytes set");

	gate_open_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(sel_dp && cnt_mode && gate_s2_q[0] && !gate_prev_q[0] && software_count_gate_in[0]
			&& cnt_en_q[3]) |=> pend_q[0])
		else $error("gate opening not queued");

	ack_end_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(process_irq_out && wr_acc && paddr_in == io_irq_pkg::CAUSE_OFS) |=> !process_irq_out)
		else $error("routine did not end on ack");

endmodule

`default_nettype wire

// file: io_irq_pkg.sv
/*
 * constants for the i/o process and diagnostic interrupt event block:
 * apb register offsets, field positions, reset values and interrupt selections.
 * assumes a 32-bit apb bus with one aligned word for each register.
 */
`default_nettype none

package io_irq_pkg;

	// register byte offsets
	localparam logic [7:0] CTRL_OFS    = 8'h00;
	localparam logic [7:0] DI_EN_OFS   = 8'h04;
	localparam logic [7:0] DI_EDGE_OFS = 8'h08;
	localparam logic [7:0] CNT_EN_OFS  = 8'h0c;
	localparam logic [7:0] DIAG_EN_OFS = 8'h10;
	localparam logic [7:0] BASE_OFS    = 8'h14;
	localparam logic [7:0] CAUSE_OFS   = 8'h18;
	localparam logic [7:0] STATUS_OFS  = 8'h1c;

	// interrupt selection field of the control register
	typedef enum logic [1:0] {
		SEL_NONE      = 2'h0,
		SEL_DIAG      = 2'h1,
		SEL_DIAG_PROC = 2'h2
	} irq_sel_t;

	// control register fields
	localparam int SEL_LSB  = 0;
	localparam int MODE_BIT = 2;

	// digital edge register: rising edges low half, falling edges high half
	localparam int FALL_LSB = 16;

	// per counter enable nibble and per counter cause byte
	localparam int CEN_CMP   = 0;
	localparam int CEN_OVF   = 1;
	localparam int CEN_UNF   = 2;
	localparam int CEN_GATE  = 3;
	localparam int CB_GOPEN  = 0;
	localparam int CB_GCLOSE = 1;
	localparam int CB_OVUN   = 2;
	localparam int CB_CMP    = 3;

	// diagnostic flag positions
	localparam int DG_LOST  = 0;
	localparam int DG_DOPWR = 1;
	localparam int DG_DIPWR = 2;
	localparam int DG_SHORT = 3;
	localparam int STAT_DIAG_LSB = 4;

	// reset values
	localparam logic [31:0] REG_RST = 32'h0000_0000;

endpackage

`default_nettype wire

// file: field_inputs_model.sv
/* field_inputs_model: digital field pins and hardware count gates.
   assumes the bench asks for a toggle by pulsing a flip bit for one cycle. */
`timescale 1ns/1ns
`default_nettype none
module field_inputs_model (
	input  wire logic        clk_in,
	input  wire logic [15:0] di_flip_in,
	input  wire logic [3:0]  gate_flip_in,
	output var  logic [15:0] di_out,
	output var  logic [3:0]  gate_out
);
	// pins start low; each toggle is one edge seen by the block
	initial begin
		di_out = 16'h0000;
		gate_out = 4'h0;
	end
	always @(posedge clk_in) begin
		di_out <= di_out ^ di_flip_in;
		gate_out <= gate_out ^ gate_flip_in;
	end
endmodule
`default_nettype wire

// file: io_irq_events_tb.sv
/* io_irq_events_tb: self-checking bench for the interrupt event block.
   assumes field_inputs_model drives the field pins. */
`timescale 1ns/1ns
`default_nettype none
module io_irq_events_tb;
	logic             clk = 1'h0;
	logic             srst = 1'h1;
	logic             psel = 1'h0;
	logic             pen = 1'h0;
	logic             pwr = 1'h0;
	logic [7:0]       paddr = 8'h00;
	logic [31:0]      pwdata = 32'h0;
	logic [31:0]      prdata, rd, cause;
	logic             pready, pslverr, irq, dirq, err;
	logic             prev = 1'h0;
	logic [15:0]      di, baddr, base;
	logic [15:0]      dflip = 16'h0;
	logic [3:0]       gate;
	logic [3:0]       gflip = 4'h0;
	logic [3:0]       sgate = 4'hf;
	logic [3:0]       ovf = 4'h0;
	logic [3:0]       unf = 4'h0;
	logic [2:0]       flt = 3'h0;
	logic [3:0][31:0] val, cmp;
	logic [47:0]      expq[$];
	int               fails = 0;
	int               checks_done = 0;

	always #10 clk = ~clk;

	field_inputs_model fm (.clk_in(clk), .di_flip_in(dflip), .gate_flip_in(gflip),
		.di_out(di), .gate_out(gate));
	io_irq_events uut (.clk_in(clk), .srst_in(srst), .psel_in(psel), .penable_in(pen),
		.pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .di_in(di), .cnt_value_in(val),
		.cnt_cmp_in(cmp), .cnt_ovf_in(ovf), .cnt_unf_in(unf),
		.hardware_count_gate_in(gate), .software_count_gate_in(sgate),
		.do_supply_fail_in(flt[0]), .di_supply_fail_in(flt[1]), .do_short_in(flt[2]),
		.process_irq_out(irq), .cause_out(cause), .base_addr_out(baddr),
		.diag_irq_out(dirq));

	task automatic complete_run;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1)
			@(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		pen <= 1'h0;
		@(posedge clk);
	endtask

	// bounded wait on the process line (d=0) or the diagnostic line (d=1)
	task automatic wait_for(input logic lvl, input bit d);
		int n;
		n = 0;
		// look off the launching edge, and hand back on a rising edge
		@(negedge clk);
		while ((d ? dirq : irq) !== lvl && n < 40) begin
			@(negedge clk);
			n++;
		end
		chk(d ? "diag irq" : "process irq", {47'h0, lvl}, {47'h0, d ? dirq : irq});
		@(posedge clk);
	endtask

	task automatic flip(input logic [15:0] f, input logic [3:0] g);
		dflip <= f;
		gflip <= g;
		@(posedge clk);
		dflip <= 16'h0;
		gflip <= 4'h0;
		@(posedge clk);
	endtask

	// the routine answers after a random delay, promptly or slowly
	task automatic expect_irq(input logic [31:0] c);
		expq.push_back({base, c});
		wait_for(1'h1, 1'b0);
		repeat ($urandom_range(1, 8)) @(posedge clk);
		apb(1'h1, io_irq_pkg::CAUSE_OFS, 32'h0);
		wait_for(1'h0, 1'b0);
	endtask

	task automatic no_irq;
		repeat (15) @(negedge clk);
		chk("quiet", 48'h0, {47'h0, irq});
		@(posedge clk);
	endtask

	// cause and base are compared on the routine's start, off the launching edge
	always @(negedge clk) begin
		prev <= irq;
		if (irq === 1'h1 && prev !== 1'h1) begin
			if (expq.size() == 0)
				chk("unexpected irq", 48'h0, 48'h1);
			else
				chk("cause and base", expq.pop_front(), {baddr, cause});
		end
	end

	initial begin
		#(20 * 20000);
		fails++;
		$display("ERROR watchdog expected done seen hang");
		complete_run;
	end

	initial begin
		void'($urandom(32'hcdfb525c));
		base = 16'($urandom());
		for (int i = 0; i < 4; i++) begin
			val[i] = $urandom();
			cmp[i] = ~val[i];
		end
		repeat (4) @(posedge clk);
		srst <= 1'h0;
		@(posedge clk);
		apb(1'h0, io_irq_pkg::CTRL_OFS, 32'h0);
		chk("ctrl reset", {16'h0, io_irq_pkg::REG_RST}, {16'h0, rd});
		apb(1'h1, io_irq_pkg::DI_EN_OFS, 32'h0000ffff);
		apb(1'h1, io_irq_pkg::DI_EDGE_OFS, 32'hffffffff);
		apb(1'h1, io_irq_pkg::CNT_EN_OFS, 32'h0000ffff);
		apb(1'h1, io_irq_pkg::DIAG_EN_OFS, 32'h0000000f);
		apb(1'h1, io_irq_pkg::BASE_OFS, {16'h0, base});
		apb(1'h1, io_irq_pkg::CTRL_OFS, 32'h00000001);
		flip(16'h0001 << $urandom_range(0, 15), 4'h0);
		no_irq();
		apb(1'h1, io_irq_pkg::CTRL_OFS, 32'h00000002);
		for (int n = 0; n < 16; n++) begin
			flip(16'h0001 << n, 4'h0);
			expect_irq(32'h1 << n);
		end
		$display("test digital done");
		flip(16'h0001, 4'h0);
		expq.push_back({base, 32'h1});
		wait_for(1'h1, 1'b0);
		flip(16'h0001, 4'h0);
		wait_for(1'h1, 1'b1);
		apb(1'h1, io_irq_pkg::CAUSE_OFS, 32'h0);
		// the lost edge stays pending and is served again after the ack
		expect_irq(32'h1);
		apb(1'h0, io_irq_pkg::STATUS_OFS, 32'h0);
		chk("lost flag", {16'h0, 32'h1 << io_irq_pkg::STAT_DIAG_LSB}, {16'h0, rd});
		for (int f = 0; f < 3; f++) begin
			apb(1'h1, io_irq_pkg::STATUS_OFS, 32'h000000f0);
			wait_for(1'h0, 1'b1);
			flt <= 3'h1 << f;
			wait_for(1'h1, 1'b1);
			flt <= 3'h0;
			apb(1'h0, io_irq_pkg::STATUS_OFS, 32'h0);
			chk("fault flag", {16'h0, 32'h1 << (io_irq_pkg::STAT_DIAG_LSB + 1 + f)}, {16'h0, rd});
		end
		apb(1'h1, io_irq_pkg::STATUS_OFS, 32'h000000f0);
		$display("test diag done");
		apb(1'h1, io_irq_pkg::CTRL_OFS, 32'h00000006);
		for (int c = 0; c < 4; c++) begin
			ovf <= 4'h1 << c;
			@(posedge clk);
			ovf <= 4'h0;
			expect_irq(32'h4 << (8 * c));
			unf <= 4'h1 << c;
			@(posedge clk);
			unf <= 4'h0;
			expect_irq(32'h4 << (8 * c));
			cmp[c] <= val[c];
			expect_irq(32'h8 << (8 * c));
			cmp[c] <= ~val[c];
			for (int g = 0; g < 2; g++) begin
				flip(16'h0, 4'h1 << c);
				if (c < 3)
					expect_irq(32'h1 << (8 * c + g));
				else
					no_irq();
			end
		end
		// closed software gate masks hardware gate changes
		sgate <= 4'h0;
		flip(16'h0, 4'h1);
		flip(16'h0, 4'h1);
		no_irq();
		$display("test counter done");
		apb(1'h0, 8'h20, 32'h0);
		chk("unmapped", 48'h0001_0000_0000, {15'h0, err, rd});
		$display("test unmapped done");
		complete_run;
	end
endmodule
`default_nettype wire
